//--- rtl/feed_gate_pkg.sv
package feed_gate_pkg;

  // ---------------------------------------------------------------
  // register offsets (byte addresses, one word each)
  // ---------------------------------------------------------------
  localparam int            ADDR_W          = 8;
  localparam logic [7:0]    OFF_FEED_GATING = 8'h00;
  localparam logic [7:0]    OFF_DRIVE_SENS  = 8'h04;
  localparam logic [7:0]    OFF_MON_WINDOW  = 8'h08;
  localparam logic [7:0]    OFF_COUPLING    = 8'h0C;
  localparam logic [7:0]    OFF_MAX_VEL     = 8'h10;
  localparam logic [7:0]    OFF_LOOP_GAIN   = 8'h14;
  localparam logic [7:0]    OFF_STATUS      = 8'h18;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int FG_ANGLE_LSB  = 0;
  localparam int FG_HOLD_LSB   = 8;
  localparam int FG_DECEL_LSB  = 24;
  localparam int DS_RPM_LSB    = 0;
  localparam int DS_VOLT_LSB   = 16;
  localparam int MW_PCT_LSB    = 0;
  localparam int MW_ERROUT_LSB = 16;
  localparam int MW_DIGIT_LSB  = 28;
  localparam int CP_MWIN_LSB   = 0;
  localparam int CP_DEV_LSB    = 8;
  localparam int CP_MASTER_LSB = 24;
  localparam int CP_MODE_LSB   = 28;

  // status bits
  localparam int ST_ANGLE_ERR = 0;
  localparam int ST_RUNAWAY   = 1;
  localparam int ST_LAG       = 2;
  localparam int ST_FEED_RUN  = 3;
  localparam int ST_FEED_WAIT = 4;
  localparam int ST_FEED_HELD = 5;
  localparam int ST_WHEEL_ACT = 6;

  // ---------------------------------------------------------------
  // accepted ranges and codes
  // ---------------------------------------------------------------
  localparam logic [13:0] RPM_MIN       = 14'h0001;
  localparam logic [13:0] RPM_MAX       = 14'h270F;
  localparam logic [13:0] VOLT_MIN      = 14'h0005;
  localparam logic [13:0] VOLT_MAX      = 14'h0064;
  localparam logic [7:0]  PCT_MIN       = 8'h01;
  localparam logic [7:0]  PCT_MAX       = 8'h64;
  localparam logic [7:0]  DEV_MAX       = 8'h63;
  localparam logic [7:0]  AUX_NONE      = 8'h00;
  localparam logic [3:0]  DIGIT_REPORT  = 4'h0;
  localparam logic [3:0]  DIGIT_SILENT  = 4'h8;
  localparam logic [3:0]  MASTER_AXIS1  = 4'h1;
  localparam logic [3:0]  MASTER_AXIS3  = 4'h3;
  localparam logic [3:0]  MASTER_WHEEL  = 4'h5;

  // following error scaling: vmax * 60 / (kv * 1000), window in percent
  localparam logic [79:0] FE_MUL_NUM = 80'h3C;
  localparam logic [79:0] FE_MUL_DEN = 80'h186A0;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] RST_FEED_GATING = 32'h0000_0000;
  localparam logic [31:0] RST_DRIVE_SENS  = 32'h0064_07D0;
  localparam logic [31:0] RST_MON_WINDOW  = 32'h0000_000A;
  localparam logic [31:0] RST_COUPLING    = 32'h0000_0000;
  localparam logic [31:0] RST_MAX_VEL     = 32'h0000_1388;
  localparam logic [31:0] RST_LOOP_GAIN   = 32'h0000_0190;

  typedef enum logic [2:0] {
    MODE_NORMAL, MODE_SYNC, MODE_FOLLOW, MODE_WHEEL1, MODE_WHEEL2
  } coupling_mode_t;

  typedef enum logic [1:0] {
    FEED_IDLE, FEED_WAIT, FEED_RUN, FEED_HELD
  } feed_state_t;

endpackage

//--- rtl/feed_gate_lag_monitor.sv
`timescale 1ns/1ps

module feed_gate_lag_monitor #(
  parameter int AUX_N = 24
) (
  input  wire logic                         i_clk,
  input  wire logic                         i_rstn,
  input  wire logic                         i_psel,
  input  wire logic                         i_penable,
  input  wire logic                         i_pwrite,
  input  wire logic [feed_gate_pkg::ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]                  i_pwdata,
  output logic      [31:0]                  o_prdata,
  output logic                              o_pready,
  output logic                              o_pslverr,
  input  wire logic                         i_cycle_tick,
  input  wire logic                         i_axis_enable,
  input  wire logic [AUX_N-1:0]             i_aux_in,
  input  wire logic                         i_block_valid,
  input  wire logic                         i_block_has_feed,
  input  wire logic                         i_feed_done,
  input  wire logic                         i_decel_active,
  input  wire logic signed [31:0]           i_actual_pos,
  input  wire logic signed [31:0]           i_model_pos,
  output logic                              o_block_accept,
  output logic                              o_feed_run,
  output logic                              o_error,
  output logic      [AUX_N-1:0]             o_aux_out,
  output feed_gate_pkg::coupling_mode_t     o_coupling_mode,
  output logic      [3:0]                   o_master_sel,
  output logic                              o_wheel_active
);
  import feed_gate_pkg::*;

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (AUX_N < 1 || AUX_N > 99) begin : g_bad_aux
    $error("AUX_N must lie in 1..99");
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  logic [31:0] feed_gating_setting;
  logic [31:0] drive_sensitivity_setting;
  logic [31:0] monitor_window_setting;
  logic [31:0] axis_coupling_setting;
  logic [31:0] max_velocity;
  logic [31:0] position_loop_gain;
  logic        angle_err;
  logic        runaway_err;
  logic        lag_err;
  feed_state_t state;

  wire logic [7:0]  angle_num  = feed_gating_setting[FG_ANGLE_LSB +: 8];
  wire logic [7:0]  hold_num   = feed_gating_setting[FG_HOLD_LSB +: 8];
  wire logic [7:0]  decel_num  = feed_gating_setting[FG_DECEL_LSB +: 8];
  wire logic [7:0]  win_pct    = monitor_window_setting[MW_PCT_LSB +: 8];
  wire logic [7:0]  errout_num = monitor_window_setting[MW_ERROUT_LSB +: 8];
  wire logic        report_on  = monitor_window_setting[MW_DIGIT_LSB +: 4] == DIGIT_REPORT;
  wire logic [7:0]  wheel_num  = axis_coupling_setting[CP_MWIN_LSB +: 8];

  // pick one numbered auxiliary input; zero or out of range reads low
  function automatic logic aux_pick(input logic [7:0] num, input logic [AUX_N-1:0] bits);
    logic r;
    r = 1'b0;
    for (int i = 0; i < AUX_N; i++) begin
      if (num == 8'(i + 1)) begin
        r = bits[i];
      end
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // write validation: out-of-range words are refused with pslverr
  // ---------------------------------------------------------------
  logic aux_lim;
  logic wr_valid;
  logic mapped;
  always_comb begin
    logic [13:0] rpm;
    logic [13:0] volt;
    logic [3:0]  digit;
    logic [3:0]  mode;
    logic [3:0]  mst;
    rpm      = i_pwdata[DS_RPM_LSB +: 14];
    volt     = i_pwdata[DS_VOLT_LSB +: 14];
    digit    = i_pwdata[MW_DIGIT_LSB +: 4];
    mode     = i_pwdata[CP_MODE_LSB +: 4];
    mst      = i_pwdata[CP_MASTER_LSB +: 4];
    aux_lim  = 1'b1;
    wr_valid = 1'b1;
    mapped   = 1'b1;
    case (i_paddr)
      OFF_FEED_GATING: begin
        wr_valid = i_pwdata[FG_ANGLE_LSB +: 8] <= 8'(AUX_N) && i_pwdata[FG_HOLD_LSB +: 8] <= 8'(AUX_N)
                   && i_pwdata[FG_DECEL_LSB +: 8] <= 8'(AUX_N);
      end
      OFF_DRIVE_SENS: begin
        wr_valid = rpm >= RPM_MIN && rpm <= RPM_MAX && volt >= VOLT_MIN && volt <= VOLT_MAX;
      end
      OFF_MON_WINDOW: begin
        wr_valid = (digit == DIGIT_REPORT || digit == DIGIT_SILENT)
                   && i_pwdata[MW_PCT_LSB +: 8] >= PCT_MIN && i_pwdata[MW_PCT_LSB +: 8] <= PCT_MAX
                   && i_pwdata[MW_ERROUT_LSB +: 8] <= 8'(AUX_N);
      end
      OFF_COUPLING: begin
        aux_lim  = i_pwdata[CP_MWIN_LSB +: 8] <= 8'(AUX_N);
        wr_valid = mode <= 4'(MODE_WHEEL2) && aux_lim
                   && i_pwdata[CP_DEV_LSB +: 8] <= DEV_MAX;
        if (mode == 4'(MODE_SYNC)) begin
          wr_valid = wr_valid && (mst == MASTER_AXIS1 || mst == MASTER_AXIS3);
        end
        if (mode == 4'(MODE_FOLLOW)) begin
          wr_valid = wr_valid && (mst == MASTER_AXIS1 || mst == MASTER_AXIS3 || mst == MASTER_WHEEL);
        end
      end
      OFF_MAX_VEL, OFF_LOOP_GAIN, OFF_STATUS: begin
        wr_valid = 1'b1;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // apb slave: one wait-free access phase, read data latched at setup
  // ---------------------------------------------------------------
  wire logic setup  = i_psel && !i_penable;
  wire logic commit = i_psel && i_penable && o_pready;
  wire logic wr_go  = commit && i_pwrite && !o_pslverr;

  // handshake: pready for exactly the access cycle after setup
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= setup;
      o_pslverr <= setup && (!mapped || (i_pwrite && !wr_valid));
    end
  end

  // read data captured at setup so it stands registered in access
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_prdata <= 32'h0000_0000;
    end else if (setup && !i_pwrite) begin
      case (i_paddr)
        OFF_FEED_GATING: o_prdata <= feed_gating_setting;
        OFF_DRIVE_SENS:  o_prdata <= drive_sensitivity_setting;
        OFF_MON_WINDOW:  o_prdata <= monitor_window_setting;
        OFF_COUPLING:    o_prdata <= axis_coupling_setting;
        OFF_MAX_VEL:     o_prdata <= max_velocity;
        OFF_LOOP_GAIN:   o_prdata <= position_loop_gain;
        OFF_STATUS: begin
          o_prdata <= 32'h0000_0000;
          o_prdata[ST_ANGLE_ERR] <= angle_err;
          o_prdata[ST_RUNAWAY]   <= runaway_err;
          o_prdata[ST_LAG]       <= lag_err;
          o_prdata[ST_FEED_RUN]  <= state == FEED_RUN;
          o_prdata[ST_FEED_WAIT] <= state == FEED_WAIT;
          o_prdata[ST_FEED_HELD] <= state == FEED_HELD;
          o_prdata[ST_WHEEL_ACT] <= o_wheel_active;
        end
        default:         o_prdata <= 32'h0000_0000;
      endcase
    end
  end

  // configuration words; a refused write leaves the old value
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      feed_gating_setting       <= RST_FEED_GATING;
      drive_sensitivity_setting <= RST_DRIVE_SENS;
      monitor_window_setting    <= RST_MON_WINDOW;
      axis_coupling_setting     <= RST_COUPLING;
      max_velocity              <= RST_MAX_VEL;
      position_loop_gain        <= RST_LOOP_GAIN;
    end else if (wr_go) begin
      case (i_paddr)
        OFF_FEED_GATING: feed_gating_setting       <= i_pwdata;
        OFF_DRIVE_SENS:  drive_sensitivity_setting <= i_pwdata;
        OFF_MON_WINDOW:  monitor_window_setting    <= i_pwdata;
        OFF_COUPLING:    axis_coupling_setting     <= i_pwdata;
        OFF_MAX_VEL:     max_velocity              <= i_pwdata;
        OFF_LOOP_GAIN:   position_loop_gain        <= i_pwdata;
        default:         ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // gating inputs, sampled only at the control cycle boundary
  // ---------------------------------------------------------------
  wire logic angle_on = angle_num != AUX_NONE;
  wire logic hold_on  = hold_num != AUX_NONE;
  wire logic angle_ok = !angle_on || aux_pick(angle_num, i_aux_in);
  wire logic hold_ok  = !hold_on || aux_pick(hold_num, i_aux_in);
  wire logic clr_hit  = wr_go && i_paddr == OFF_STATUS;
  logic      angle_set;

  // feed sequencing; angle loss outranks hold so it is never masked
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state          <= FEED_IDLE;
      o_block_accept <= 1'b0;
    end else begin
      o_block_accept <= 1'b0;
      if (i_cycle_tick) begin
        case (state)
          FEED_IDLE: begin
            if (i_block_valid && !i_block_has_feed) begin
              o_block_accept <= 1'b1;
            end else if (i_block_valid && angle_ok && hold_ok) begin
              o_block_accept <= 1'b1;
              state          <= FEED_RUN;
            end else if (i_block_valid) begin
              state <= FEED_WAIT;
            end
          end
          FEED_WAIT: begin
            if (angle_ok && hold_ok) begin
              o_block_accept <= 1'b1;
              state          <= FEED_RUN;
            end
          end
          FEED_RUN: begin
            if (!angle_ok) begin
              state <= FEED_IDLE;
            end else if (!hold_ok) begin
              state <= FEED_HELD;
            end else if (i_feed_done) begin
              state <= FEED_IDLE;
            end
          end
          FEED_HELD: begin
            if (!angle_ok) begin
              state <= FEED_IDLE;
            end else if (hold_ok) begin
              state <= FEED_RUN;
            end
          end
          default: state <= FEED_IDLE;
        endcase
      end
    end
  end

  assign angle_set = i_cycle_tick && (state == FEED_RUN || state == FEED_HELD) && !angle_ok;

  // feed command level follows the state a cycle late, from a flop
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_feed_run <= 1'b0;
    end else begin
      o_feed_run <= state == FEED_RUN;
    end
  end

  // ---------------------------------------------------------------
  // following error window, no divider: both sides cross-multiplied
  // ---------------------------------------------------------------
  // kv of zero makes the left side zero, so the window never trips
  logic signed [32:0] dev;
  logic        [32:0] dev_abs;
  // 96 bits: a 33-bit deviation times a 32-bit gain times 1e5 overflows 80
  logic        [95:0] lhs;
  logic        [95:0] rhs;
  logic               beyond;
  always_comb begin
    dev     = 33'(i_actual_pos) - 33'(i_model_pos);
    dev_abs = dev[32] ? 33'(-dev) : dev;
    lhs     = 96'(dev_abs) * 96'(position_loop_gain) * 96'(FE_MUL_DEN);
    rhs     = 96'(win_pct) * 96'(max_velocity) * 96'(FE_MUL_NUM);
    beyond  = lhs > rhs;
  end

  wire logic check_now   = i_cycle_tick && i_axis_enable;
  wire logic runaway_hit = check_now && beyond && !dev[32];
  wire logic lag_hit     = check_now && beyond && dev[32];
  logic      pos_err_out;

  // sticky errors, cleared by writing ones to status; a set wins
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      angle_err   <= 1'b0;
      runaway_err <= 1'b0;
      lag_err     <= 1'b0;
    end else begin
      angle_err   <= (angle_err && !(clr_hit && i_pwdata[ST_ANGLE_ERR])) || angle_set;
      runaway_err <= (runaway_err && !(clr_hit && i_pwdata[ST_RUNAWAY]))
                     || (runaway_hit && report_on);
      lag_err     <= (lag_err && !(clr_hit && i_pwdata[ST_LAG])) || (lag_hit && report_on);
    end
  end

  // error summary and the suppressed-mode positioning-error level
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_error     <= 1'b0;
      pos_err_out <= 1'b0;
    end else begin
      o_error <= angle_err || runaway_err || lag_err;
      if (i_cycle_tick) begin
        pos_err_out <= !report_on && (runaway_hit || lag_hit);
      end
    end
  end

  // decel indication tracked per control cycle
  logic decel_q;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      decel_q <= 1'b0;
    end else if (i_cycle_tick) begin
      decel_q <= i_decel_active && decel_num != AUX_NONE;
    end
  end

  // ---------------------------------------------------------------
  // auxiliary outputs, one flop per numbered output
  // ---------------------------------------------------------------
  for (genvar g = 0; g < AUX_N; g++) begin : g_aux
    always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        o_aux_out[g] <= 1'b0;
      end else begin
        o_aux_out[g] <= (decel_num == 8'(g + 1) && decel_q)
                        || (errout_num == 8'(g + 1) && pos_err_out);
      end
    end
  end

  // ---------------------------------------------------------------
  // coupling decode and measuring wheel activation
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_coupling_mode <= MODE_NORMAL;
      o_master_sel    <= 4'h0;
      o_wheel_active  <= 1'b0;
    end else begin
      o_coupling_mode <= coupling_mode_t'(axis_coupling_setting[CP_MODE_LSB +: 3]);
      o_master_sel    <= axis_coupling_setting[CP_MASTER_LSB +: 4];
      if (i_cycle_tick) begin
        o_wheel_active <= wheel_num != AUX_NONE && aux_pick(wheel_num, i_aux_in)
                          && (axis_coupling_setting[CP_MODE_LSB +: 4] == 4'(MODE_WHEEL1)
                          || axis_coupling_setting[CP_MODE_LSB +: 4] == 4'(MODE_WHEEL2));
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  sequence seq_setup;
    i_psel && !i_penable;
  endsequence
  sequence seq_bad_sens;
    seq_setup and (i_pwrite && i_paddr == OFF_DRIVE_SENS && i_pwdata[DS_RPM_LSB +: 14] == 14'h0000);
  endsequence

  a_apb_ready_once: assert property (seq_setup |=> o_pready ##1 !o_pready)
    else $error("pready not a single access cycle");
  a_sens_range_refuse: assert property (
      seq_bad_sens |=> o_pslverr ##1 $stable(drive_sensitivity_setting))
    else $error("out-of-range rpm accepted");
  a_feedless_accept: assert property (
      i_cycle_tick && state == FEED_IDLE && i_block_valid && !i_block_has_feed
      |=> o_block_accept && state == FEED_IDLE)
    else $error("feedless block not passed");
  a_wait_no_feed: assert property (state == FEED_WAIT |=> !o_feed_run && !$rose(angle_err))
    else $error("feed or error while waiting");
  a_angle_drop_stop: assert property (
      i_cycle_tick && state == FEED_RUN && !angle_ok
      |=> angle_err && state == FEED_IDLE ##1 !o_feed_run)
    else $error("angle drop did not stop feed");
  a_hold_stop_quiet: assert property (
      i_cycle_tick && state == FEED_RUN && angle_ok && !hold_ok && !angle_err
      |=> state == FEED_HELD && !angle_err ##1 !o_feed_run)
    else $error("hold did not pause quietly");
  a_hold_resume: assert property (
      i_cycle_tick && state == FEED_HELD && angle_ok && hold_ok
      |=> state == FEED_RUN ##1 o_feed_run)
    else $error("feed not resumed after hold");
  a_runaway_report: assert property (runaway_hit && report_on |=> runaway_err ##1 o_error)
    else $error("runaway not flagged");
  a_lag_report: assert property (lag_hit && report_on |=> lag_err && !$rose(runaway_err))
    else $error("lag not flagged");
  a_silent_output: assert property (
      i_cycle_tick && !report_on && (runaway_hit || lag_hit)
      |=> pos_err_out && !$rose(runaway_err) && !$rose(lag_err))
    else $error("suppressed mode misbehaved");

endmodule // feed_gate_lag_monitor

//--- tb/drive_aux_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// drive, encoder and aux input model
// ----------------------------------------
module drive_aux_model #(
  parameter int AUX_N = 24
) (
  input  wire logic               i_angle_on,
  input  wire logic               i_hold_rel,
  input  wire logic signed [31:0] i_lag,
  input  wire logic signed [31:0] i_model_pos,
  output logic        [AUX_N-1:0] o_aux_in,
  output logic signed [31:0]      o_actual_pos
);
  // angle on aux 1, hold on aux 2: never the same input
  assign o_aux_in = {{(AUX_N-2){1'h0}}, i_hold_rel, i_angle_on};
  // encoder runs ahead of the model by the lag under test
  assign o_actual_pos = i_model_pos + i_lag;
endmodule // drive_aux_model

//--- tb/feed_gate_lag_monitor_tb.sv
`timescale 1ns/1ps
module feed_gate_lag_monitor_tb;
  import feed_gate_pkg::*;
  logic               clk = 0, rstn = 0, psel = 0, pen = 0, pw = 0, tick = 0, axen = 0;
  logic               bv = 0, bf = 0, fdone = 0, decel = 0, angle = 0, hold_rel = 1;
  logic [7:0]         pa = 8'h00;
  logic [31:0]        pwd = 32'h0, prdata, rd;
  logic               pready, pslverr, rerr, acc, frun, err_o, wact;
  logic [23:0]        aux_in, aux_out;
  logic signed [31:0] act, lag = 32'sh0, mpos = 32'sh1000;
  logic [3:0]         msel;
  logic [1:0]         cnt = 2'h0;
  coupling_mode_t     mode;
  int                 failures = 0, cmp_count = 0;
  always #25 clk = ~clk;
  // control cycle tick, one clk in four
  always @(posedge clk) begin
    cnt <= cnt + 2'h1;
    tick <= (cnt == 2'h3);
  end
  feed_gate_lag_monitor dut (.i_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(pen), .i_pwrite(pw),
    .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_cycle_tick(tick), .i_axis_enable(axen), .i_aux_in(aux_in), .i_block_valid(bv),
    .i_block_has_feed(bf), .i_feed_done(fdone), .i_decel_active(decel), .i_actual_pos(act),
    .i_model_pos(mpos), .o_block_accept(acc), .o_feed_run(frun), .o_error(err_o), .o_aux_out(aux_out),
    .o_coupling_mode(mode), .o_master_sel(msel), .o_wheel_active(wact));
  drive_aux_model far (.i_angle_on(angle), .i_hold_rel(hold_rel), .i_lag(lag), .i_model_pos(mpos),
    .o_aux_in(aux_in), .o_actual_pos(act));
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      failures++;
    end
  endtask
  // waits end on a rising edge, so stimulus after them is driven there
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // apb master: hold request until pready seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'h1;
    pw <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'h1;
    // pready and read data are sampled at the same rising edge
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      failures++;
      end_of_test();
    end
    rd = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask
  // present a block; it stays pending until accepted
  task automatic blk(input logic f, input logic exp);
    int n;
    n = 0;
    @(posedge clk);
    bv <= 1'h1;
    bf <= f;
    while (acc !== 1'h1 && n < 16) begin
      @(posedge clk);
      n++;
    end
    chk(acc, exp);
    if (acc === 1'h1) begin
      bv <= 1'h0;
    end else if (exp === 1'h1) begin
      end_of_test();
    end
  endtask
  task automatic t_regs();
    apb(1'h0, OFF_DRIVE_SENS, 32'h0);
    chk(rd, RST_DRIVE_SENS);
    apb(1'h0, OFF_MON_WINDOW, 32'h0);
    chk(rd, RST_MON_WINDOW);
    apb(1'h1, OFF_DRIVE_SENS, 32'h0064_0000);
    chk(rerr, 1'h1);
    apb(1'h1, OFF_DRIVE_SENS, 32'h0004_07D0);
    chk(rerr, 1'h1);
    apb(1'h1, OFF_MON_WINDOW, 32'h0000_0065);
    chk(rerr, 1'h1);
    for (int m = 0; m < 5; m++) begin
      apb(1'h1, OFF_COUPLING, {m[3:0], 4'h1, 24'h0});
      wt(2);
      chk(mode, m);
    end
    apb(1'h1, OFF_COUPLING, 32'h1500_0000);
    chk(rerr, 1'h1);
    apb(1'h1, OFF_COUPLING, 32'h2500_0000);
    wt(2);
    chk(msel, 4'h5);
    apb(1'h0, 8'h1C, 32'h0);
    chk(rerr, 1'h1);
    chk(rd, 32'h0);
    $display("register test done");
  endtask
  task automatic t_gate();
    blk(1'h1, 1'h1);
    fdone <= 1'h1;
    wt(8);
    fdone <= 1'h0;
    apb(1'h1, OFF_FEED_GATING, 32'h0300_0201);
    blk(1'h0, 1'h1);
    blk(1'h1, 1'h0);
    chk(err_o, 1'h0);
    angle <= 1'h1;
    blk(1'h1, 1'h1);
    decel <= 1'h1;
    wt(8);
    chk({frun, aux_out[2]}, 2'h3);
    angle <= 1'h0;
    wt(8);
    chk({frun, err_o}, 2'h1);
    $display("gating test done");
  endtask
  task automatic t_hold();
    apb(1'h1, OFF_STATUS, 32'h7);
    angle <= 1'h1;
    hold_rel <= 1'h0;
    // feedless first: a waiting feed block stalls the sequencer
    blk(1'h0, 1'h1);
    blk(1'h1, 1'h0);
    blk(1'h1, 1'h0);
    apb(1'h0, OFF_STATUS, 32'h0);
    chk(rd[5:0], 32'h10);
    hold_rel <= 1'h1;
    blk(1'h1, 1'h1);
    hold_rel <= 1'h0;
    wt(8);
    chk({frun, err_o}, 2'h0);
    apb(1'h0, OFF_STATUS, 32'h0);
    chk(rd[5:3], 3'h4);
    hold_rel <= 1'h1;
    wt(8);
    chk(frun, 1'h1);
    fdone <= 1'h1;
    wt(8);
    fdone <= 1'h0;
    apb(1'h1, OFF_COUPLING, 32'h3000_0001);
    wt(8);
    chk(wact, 1'h1);
    $display("hold test done");
  endtask
  // kv of 1 puts the window edge at a deviation of 30
  task automatic t_window();
    apb(1'h1, OFF_LOOP_GAIN, 32'h1);
    axen <= 1'h1;
    lag <= 32'sh1E;
    wt(8);
    apb(1'h0, OFF_STATUS, 32'h0);
    chk(rd[2:1], 2'h0);
    lag <= 32'sh1F;
    wt(8);
    apb(1'h0, OFF_STATUS, 32'h0);
    chk({rd[2:1], err_o}, 3'h3);
    // sign change first, so a late runaway set cannot beat the clear
    lag <= -32'sh1F;
    apb(1'h1, OFF_STATUS, 32'h7);
    wt(8);
    apb(1'h0, OFF_STATUS, 32'h0);
    chk(rd[2:1], 2'h2);
    apb(1'h1, OFF_MON_WINDOW, 32'h8004_000A);
    apb(1'h1, OFF_STATUS, 32'h7);
    wt(8);
    chk({err_o, aux_out[3]}, 2'h1);
    $display("window test done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'h1;
    t_regs();
    t_gate();
    t_hold();
    t_window();
    end_of_test();
  end
endmodule // feed_gate_lag_monitor_tb
